// ===== verilog/mcrb_defines.vh
`ifndef MCRB_DEFINES_VH
`define MCRB_DEFINES_VH

// register indices; the byte address on the bus is four times the index
`define MCRB_IDX_SYSINT     6'h2B
`define MCRB_IDX_CSR        6'h2C
`define MCRB_IDX_TONE       6'h2D

// reset values
`define MCRB_CSR_RESET      8'h00
`define MCRB_TONE_RESET     8'h00

// control/status field positions
`define MCRB_BIT_CLKOUT     7
`define MCRB_BIT_DIV_HI     6
`define MCRB_BIT_DIV_LO     5
`define MCRB_BIT_SLOW       4
`define MCRB_BIT_TB_HI      3
`define MCRB_BIT_TB_LO      2
`define MCRB_BIT_TIE        1
`define MCRB_BIT_FLAG       0

// tone register field positions
`define MCRB_BIT_TONE_HI    1
`define MCRB_BIT_TONE_LO    0

// time-base periods in oscillator cycles
`define MCRB_TB_PERIOD0     16000
`define MCRB_TB_PERIOD1     32000
`define MCRB_TB_PERIOD2     80000
`define MCRB_TB_PERIOD3     200000

// tone half periods in oscillator cycles (8 MHz gives 2, 1, 0.5 kHz)
`define MCRB_TONE_HALF1     2000
`define MCRB_TONE_HALF2     4000
`define MCRB_TONE_HALF3     8000

`endif

// ===== verilog/mcrb_top.v
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
// Behaviour
// - clock-out select puts cpu clock on pin
// - clock-out stops during active halt
// - divider field picks slow divide 2/4/8/16
// - slow select off means full rate
// - time-base field picks tick period
// - new period applies after current period
// - tick enable gates irq, wakes active halt
// - halt with tick enable enters active halt
// - tick flag set by hardware, read clears
// - tone field selects off or three tones
// - tone keeps running in active halt
// - registers at 2Ch, 2Dh, reset zero
// - irq needs tick enable and mask clear
// - full halt freezes counter, tick never wakes
// - active halt keeps counter running
`include "mcrb_defines.vh"

module mcrb_top #(
    parameter TB_PERIOD0 = `MCRB_TB_PERIOD0,
    parameter TB_PERIOD1 = `MCRB_TB_PERIOD1,
    parameter TB_PERIOD2 = `MCRB_TB_PERIOD2,
    parameter TB_PERIOD3 = `MCRB_TB_PERIOD3,
    parameter TONE_HALF1 = `MCRB_TONE_HALF1,
    parameter TONE_HALF2 = `MCRB_TONE_HALF2,
    parameter TONE_HALF3 = `MCRB_TONE_HALF3
)(
    input  wire        REF_CLK_IN,
    input  wire        NRST_IN,
    input  wire        PSEL_IN,
    input  wire        PENABLE_IN,
    input  wire        PWRITE_IN,
    input  wire [7:0]  PADDR_IN,
    input  wire [31:0] PWDATA_IN,
    input  wire [3:0]  PSTRB_IN,
    output reg  [31:0] PRDATA_OUT,
    output reg         PREADY_OUT,
    output reg         PSLVERR_OUT,
    input  wire        HALT_REQ_IN,
    input  wire        WAKE_IN,
    input  wire        IRQ_MASK_IN,
    output reg         CPU_CLK_EN_OUT,
    output reg         CLOCK_OUT_PIN_OUT,
    output reg         CLOCK_OUT_OE_OUT,
    output reg         TONE_PIN_OUT,
    output reg         TONE_OE_OUT,
    output reg         TICK_IRQ_OUT,
    output reg         ACTIVE_HALT_OUT,
    output reg         HALT_OUT
);

    // power states, one-hot
    localparam [2:0] ST_RUN   = 3'h1;
    localparam [2:0] ST_AHALT = 3'h2;
    localparam [2:0] ST_HALT  = 3'h4;

    // last count of each period, full width; cut to counter width where used
    localparam [31:0] TB_LAST0   = TB_PERIOD0 - 1;
    localparam [31:0] TB_LAST1   = TB_PERIOD1 - 1;
    localparam [31:0] TB_LAST2   = TB_PERIOD2 - 1;
    localparam [31:0] TB_LAST3   = TB_PERIOD3 - 1;
    localparam [31:0] TONE_LAST1 = TONE_HALF1 - 1;
    localparam [31:0] TONE_LAST2 = TONE_HALF2 - 1;
    localparam [31:0] TONE_LAST3 = TONE_HALF3 - 1;

    reg        rst_meta;
    reg        rst_n;
    reg [2:0]  mode;
    reg        clock_out_select;
    reg [1:0]  cpu_divider_select;
    reg        slow_select;
    reg [1:0]  tick_period_select;
    reg        tick_irq_enable;
    reg        tick_flag;
    reg [1:0]  tone_select;
    reg        rd_csr;
    reg [17:0] tick_cnt;
    reg [1:0]  tb_cur;
    reg [3:0]  pre_cnt;
    reg [3:0]  div_cur;
    reg [12:0] tone_cnt;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------

    // aligned word match of a register index
    function is_reg;
        input [7:0] addr;
        input [5:0] idx;
        begin
            is_reg = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
        end
    endfunction

    // last count of a time-base period
    function [17:0] tb_last;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    tb_last = TB_LAST0[17:0];
                2'h1:    tb_last = TB_LAST1[17:0];
                2'h2:    tb_last = TB_LAST2[17:0];
                default: tb_last = TB_LAST3[17:0];
            endcase
        end
    endfunction

    // last count of a cpu clock period, 0 means every cycle
    function [3:0] div_last;
        input       slow;
        input [1:0] sel;
        begin
            if (!slow)
            begin
                div_last = 4'h0;
            end
            else
            begin
                case (sel)
                    2'h0:    div_last = 4'h1;
                    2'h1:    div_last = 4'h3;
                    2'h2:    div_last = 4'h7;
                    default: div_last = 4'hF;
                endcase
            end
        end
    endfunction

    // last count of a tone half period
    function [12:0] tone_last;
        input [1:0] sel;
        begin
            case (sel)
                2'h1:    tone_last = TONE_LAST1[12:0];
                2'h2:    tone_last = TONE_LAST2[12:0];
                default: tone_last = TONE_LAST3[12:0];
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------

    // assert at once, release after two edges
    always @(posedge REF_CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------

    wire setup    = PSEL_IN & ~PENABLE_IN;
    wire done     = PSEL_IN & PENABLE_IN & PREADY_OUT;
    wire hit_csr  = is_reg(PADDR_IN, `MCRB_IDX_CSR);
    wire hit_tone = is_reg(PADDR_IN, `MCRB_IDX_TONE);
    wire hit_sys  = is_reg(PADDR_IN, `MCRB_IDX_SYSINT);
    wire running  = mode[0];
    // registers frozen outside run, so halted writes are dropped
    wire wr_ok    = done & PWRITE_IN & PSTRB_IN[0] & ~PSLVERR_OUT & running;
    wire tick_run = ~mode[2];
    wire tick_end = tick_run & (tick_cnt == tb_last(tb_cur));
    wire cpu_tick = (pre_cnt == div_cur);
    wire tick_irq = tick_flag & tick_irq_enable & ~IRQ_MASK_IN;

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------

    // data and ready are set up in the setup cycle so every access
    // completes on its first access edge without a wait state
    always @(posedge REF_CLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            PRDATA_OUT  <= 32'h0000_0000;
            PREADY_OUT  <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            rd_csr      <= 1'b0;
        end
        else
        begin
            PREADY_OUT  <= setup;
            PSLVERR_OUT <= setup & ~(hit_csr | hit_tone | hit_sys);
            rd_csr      <= setup & hit_csr & ~PWRITE_IN;
            if (setup)
            begin
                PRDATA_OUT <= 32'h0000_0000;
                if (hit_csr)
                begin
                    PRDATA_OUT[7:0] <= {clock_out_select, cpu_divider_select, slow_select,
                                        tick_period_select, tick_irq_enable, tick_flag};
                end
                else if (hit_tone)
                begin
                    PRDATA_OUT[1:0] <= tone_select;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // control and tone registers
    // ----------------------------------------------------------------

    // software fields, cleared by reset
    always @(posedge REF_CLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clock_out_select   <= 1'b0;
            cpu_divider_select <= 2'h0;
            slow_select        <= 1'b0;
            tick_period_select <= 2'h0;
            tick_irq_enable    <= 1'b0;
            tone_select        <= 2'h0;
        end
        else if (wr_ok)
        begin
            if (hit_csr)
            begin
                clock_out_select   <= PWDATA_IN[`MCRB_BIT_CLKOUT];
                cpu_divider_select <= PWDATA_IN[`MCRB_BIT_DIV_HI:`MCRB_BIT_DIV_LO];
                slow_select        <= PWDATA_IN[`MCRB_BIT_SLOW];
                tick_period_select <= PWDATA_IN[`MCRB_BIT_TB_HI:`MCRB_BIT_TB_LO];
                tick_irq_enable    <= PWDATA_IN[`MCRB_BIT_TIE];
            end
            else if (hit_tone)
            begin
                tone_select <= PWDATA_IN[`MCRB_BIT_TONE_HI:`MCRB_BIT_TONE_LO];
            end
        end
    end

    // tick flag: a tick in the clearing cycle wins, and only a flag
    // that the read actually returned is cleared, so none is lost
    always @(posedge REF_CLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_flag <= 1'b0;
        end
        else if (tick_end)
        begin
            tick_flag <= 1'b1;
        end
        else if (done & rd_csr & PRDATA_OUT[`MCRB_BIT_FLAG])
        begin
            tick_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // power state
    // ----------------------------------------------------------------

    // tick wakes only active halt; full halt needs an outside wake
    always @(posedge REF_CLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode <= ST_RUN;
        end
        else
        begin
            case (mode)
                ST_RUN:
                begin
                    if (HALT_REQ_IN)
                    begin
                        mode <= tick_irq_enable ? ST_AHALT : ST_HALT;
                    end
                end
                ST_AHALT:
                begin
                    if (WAKE_IN | tick_irq)
                    begin
                        mode <= ST_RUN;
                    end
                end
                ST_HALT:
                begin
                    if (WAKE_IN)
                    begin
                        mode <= ST_RUN;
                    end
                end
                default:
                begin
                    mode <= ST_RUN;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // time base
    // ----------------------------------------------------------------

    // the period in force is reloaded only at its own end
    always @(posedge REF_CLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_cnt <= 18'h0_0000;
            tb_cur   <= 2'h0;
        end
        else if (tick_end)
        begin
            tick_cnt <= 18'h0_0000;
            tb_cur   <= tick_period_select;
        end
        else if (tick_run)
        begin
            tick_cnt <= tick_cnt + 18'h0_0001;
        end
    end

    // ----------------------------------------------------------------
    // cpu clock prescaler
    // ----------------------------------------------------------------

    // ratio changes only at a period boundary, so no short pulse
    always @(posedge REF_CLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pre_cnt <= 4'h0;
            div_cur <= 4'h0;
        end
        else if (cpu_tick)
        begin
            pre_cnt <= 4'h0;
            div_cur <= div_last(slow_select, cpu_divider_select);
        end
        else
        begin
            pre_cnt <= pre_cnt + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------

    // clock-out toggles per cpu period; it is parked low when halted
    always @(posedge REF_CLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            CPU_CLK_EN_OUT    <= 1'b0;
            CLOCK_OUT_PIN_OUT <= 1'b0;
            CLOCK_OUT_OE_OUT  <= 1'b0;
            TICK_IRQ_OUT      <= 1'b0;
            ACTIVE_HALT_OUT   <= 1'b0;
            HALT_OUT          <= 1'b0;
        end
        else
        begin
            CPU_CLK_EN_OUT   <= cpu_tick & running;
            CLOCK_OUT_OE_OUT <= clock_out_select & running;
            if (!(clock_out_select & running))
            begin
                CLOCK_OUT_PIN_OUT <= 1'b0;
            end
            else if (cpu_tick)
            begin
                CLOCK_OUT_PIN_OUT <= ~CLOCK_OUT_PIN_OUT;
            end
            TICK_IRQ_OUT    <= tick_irq;
            ACTIVE_HALT_OUT <= mode[1];
            HALT_OUT        <= mode[2];
        end
    end

    // tone runs in run and active halt; the oscillator is off in halt
    always @(posedge REF_CLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tone_cnt     <= 13'h0000;
            TONE_PIN_OUT <= 1'b0;
            TONE_OE_OUT  <= 1'b0;
        end
        else if ((tone_select == 2'h0) || mode[2])
        begin
            tone_cnt     <= 13'h0000;
            TONE_PIN_OUT <= 1'b0;
            TONE_OE_OUT  <= 1'b0;
        end
        else
        begin
            TONE_OE_OUT <= 1'b1;
            // >= so a shorter tone picked mid-count cannot overrun
            if (tone_cnt >= tone_last(tone_select))
            begin
                tone_cnt     <= 13'h0000;
                TONE_PIN_OUT <= ~TONE_PIN_OUT;
            end
            else
            begin
                tone_cnt <= tone_cnt + 13'h0001;
            end
        end
    end

endmodule // mcrb_top

// ===== tb/mcrb_top_checker.sv
`timescale 1ns/1ns
// ----------------------------------
// port checks on the clock block
// ----------------------------------
module mcrb_checker (
    input wire       REF_CLK_IN,
    input wire       NRST_IN,
    input wire       PSEL_IN,
    input wire       PENABLE_IN,
    input wire [7:0] PADDR_IN,
    input wire       PREADY_OUT,
    input wire       PSLVERR_OUT,
    input wire       WAKE_IN,
    input wire       IRQ_MASK_IN,
    input wire       CPU_CLK_EN_OUT,
    input wire       CLOCK_OUT_PIN_OUT,
    input wire       CLOCK_OUT_OE_OUT,
    input wire       TONE_OE_OUT,
    input wire       TICK_IRQ_OUT,
    input wire       ACTIVE_HALT_OUT,
    input wire       HALT_OUT
);
    // one clock domain, so clock and reset are given once
    default clocking ck @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!NRST_IN);
    wire setup  = PSEL_IN && !PENABLE_IN;
    wire asleep = HALT_OUT || ACTIVE_HALT_OUT;
    a_ready_one:
        assert property (setup |=> PREADY_OUT ##1 !PREADY_OUT) else $error("ready not one cycle");
    a_err_unaligned:
        assert property (setup && PADDR_IN[1:0] != 2'h0 |=> PSLVERR_OUT && PREADY_OUT) else $error("no error");
    a_map_ok:
        assert property (setup && PADDR_IN inside {8'hAC, 8'hB0, 8'hB4} |=> !PSLVERR_OUT) else $error("bad error");
    a_clkout_free:
        assert property (!CLOCK_OUT_OE_OUT |-> !CLOCK_OUT_PIN_OUT) else $error("pin busy while free");
    a_clkout_halt:
        assert property (ACTIVE_HALT_OUT && $past(ACTIVE_HALT_OUT) |-> !CLOCK_OUT_OE_OUT) else $error("clock out in halt");
    a_cpu_halted:
        assert property (asleep && $past(asleep) |-> !CPU_CLK_EN_OUT && !(HALT_OUT && ACTIVE_HALT_OUT))
        else $error("cpu clock in halt");
    a_tone_halt:
        assert property (HALT_OUT && $past(HALT_OUT) |-> !TONE_OE_OUT) else $error("tone in full halt");
    a_irq_masked:
        assert property (IRQ_MASK_IN |=> !TICK_IRQ_OUT) else $error("irq while masked");
    a_halt_stays:
        assert property (HALT_OUT && !WAKE_IN && !$past(WAKE_IN) && !$past(WAKE_IN, 2) |=> HALT_OUT)
        else $error("left halt unwoken");
    // main scenarios reached
    c_tick: cover property (TICK_IRQ_OUT);
    c_active: cover property (ACTIVE_HALT_OUT);
    c_halt: cover property (HALT_OUT ##1 !HALT_OUT);
endmodule // mcrb_checker

bind mcrb_top mcrb_checker chk_u (
    .REF_CLK_IN(REF_CLK_IN), .NRST_IN(NRST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PADDR_IN(PADDR_IN), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .WAKE_IN(WAKE_IN),
    .IRQ_MASK_IN(IRQ_MASK_IN), .CPU_CLK_EN_OUT(CPU_CLK_EN_OUT), .CLOCK_OUT_PIN_OUT(CLOCK_OUT_PIN_OUT),
    .CLOCK_OUT_OE_OUT(CLOCK_OUT_OE_OUT), .TONE_OE_OUT(TONE_OE_OUT), .TICK_IRQ_OUT(TICK_IRQ_OUT),
    .ACTIVE_HALT_OUT(ACTIVE_HALT_OUT), .HALT_OUT(HALT_OUT));

// ===== tb/mcrb_pin_model.sv
`timescale 1ns/1ns
// ----------------------------------
// far-side devices on the two pins
// ----------------------------------
module mcrb_pin_model (
    input  wire clk_in,
    input  wire clock_out_pin_in,
    input  wire tone_pin_in,
    output int  clock_toggles_out,
    output int  tone_half_out
);
    logic co_last = 1'h0;
    logic tn_last = 1'h0;
    int   tn_run  = 0;
    int   co_n    = 0;
    int   tn_half = 0;
    // one driver per output
    assign clock_toggles_out = co_n;
    assign tone_half_out = tn_half;
    // count clock-out edges, time each tone half wave
    always @(posedge clk_in)
    begin
        co_last <= clock_out_pin_in;
        tn_last <= tone_pin_in;
        tn_run  <= tn_run + 1;
        if (clock_out_pin_in !== co_last)
            co_n <= co_n + 1;
        if (tone_pin_in !== tn_last)
        begin
            tn_half <= tn_run;
            tn_run  <= 1;
        end
    end
endmodule // mcrb_pin_model

// ===== tb/tb_main_clock_rtc_beeper.sv
`timescale 1ns/1ns
`include "mcrb_defines.vh"
module tb_main_clock_rtc_beeper;
// ----------------------------------
// signals and instances
// ----------------------------------
localparam logic [7:0] CSR  = {`MCRB_IDX_CSR, 2'h0};
localparam logic [7:0] TONE = {`MCRB_IDX_TONE, 2'h0};
int          per[4] = '{16, 32, 80, 200};
int          half[4] = '{0, `MCRB_TONE_HALF1, `MCRB_TONE_HALF2, `MCRB_TONE_HALF3};
int          miscompares = 0;
int          compares = 0;
int          cyc = 0;
int          co_cnt;
int          tn_half;
logic        clk = 1'h0;
logic        nrst = 1'h0;
logic        psel = 1'h0;
logic        pen = 1'h0;
logic        pwr = 1'h0;
logic        hreq = 1'h0;
logic        wake = 1'h0;
logic        mask = 1'h0;
logic        e;
logic [3:0]  pstrb = 4'hF;
logic [7:0]  paddr = 8'h00;
logic [31:0] pwdata = 32'h0;
logic [31:0] q;
wire  [31:0] prdata;
wire         pready, perr, cpu_en, co_pin, co_oe, tn_pin, tn_oe, irq, ahalt, fhalt;
// small time-base counts keep the run short; tones run at their real counts
mcrb_top #(.TB_PERIOD0(16), .TB_PERIOD1(32), .TB_PERIOD2(80), .TB_PERIOD3(200)) dut_u (
    .REF_CLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(perr), .HALT_REQ_IN(hreq), .WAKE_IN(wake),
    .IRQ_MASK_IN(mask), .CPU_CLK_EN_OUT(cpu_en), .CLOCK_OUT_PIN_OUT(co_pin),
    .CLOCK_OUT_OE_OUT(co_oe), .TONE_PIN_OUT(tn_pin), .TONE_OE_OUT(tn_oe),
    .TICK_IRQ_OUT(irq), .ACTIVE_HALT_OUT(ahalt), .HALT_OUT(fhalt));
mcrb_pin_model pm_u (.clk_in(clk), .clock_out_pin_in(co_pin), .tone_pin_in(tn_pin),
    .clock_toggles_out(co_cnt), .tone_half_out(tn_half));
// clock and a cycle count for tick timing
initial
begin
    forever #2 clk = ~clk;
end
always @(posedge clk) cyc <= cyc + 1;
// ----------------------------------
// shared tasks
// ----------------------------------
task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
        miscompares++;
        $display("FAIL %s expected %0h seen %0h", nm, exp, got);
    end
endtask
// request held until ready is seen at an edge
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                   output logic [31:0] rq, output logic re);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do
        @(posedge clk);
    while (pready !== 1'h1);
    rq = prdata;
    re = perr;
    psel <= 1'h0;
    pen <= 1'h0;
    // one idle edge so the next call never re-raises psel in this step
    @(posedge clk);
endtask
// wait for a tick, stamp it, clear it by reading
task automatic tick(output int t);
    repeat (3) @(posedge clk);
    for (int n = 0; n < 300 && irq !== 1'h1; n++)
        @(posedge clk);
    t = cyc;
    apb(1'h0, CSR, 32'h0, q, e);
    chk("flag_set", 1'h1, q[0]);
endtask
task automatic halt_now;
    hreq <= 1'h1;
    @(posedge clk);
    hreq <= 1'h0;
    repeat (3) @(posedge clk);
endtask
// ----------------------------------
// scenarios
// ----------------------------------
task automatic t_regs;
    apb(1'h0, CSR, 32'h0, q, e);
    chk("csr_reset", 32'h0, q);
    apb(1'h1, TONE, 32'h3, q, e); // reserved bits kept zero
    apb(1'h0, TONE, 32'h0, q, e);
    chk("tone_rw", 32'h3, q);
    pstrb <= 4'hE;
    apb(1'h1, TONE, 32'h0, q, e);
    pstrb <= 4'hF;
    apb(1'h0, TONE, 32'h0, q, e);
    chk("strb_refused", 32'h3, q);
    apb(1'h0, 8'hAC, 32'h0, q, e);
    chk("sysint_err", 1'h0, e);
    apb(1'h1, 8'hB1, 32'hFF, q, e);
    chk("odd_err", 1'h1, e);
    apb(1'h0, CSR, 32'h0, q, e);
    chk("csr_kept", 32'h0, q & 32'hFE);
    apb(1'h0, 8'hB8, 32'h0, q, e);
    chk("unmapped_err", 1'h1, e);
    apb(1'h1, TONE, 32'h0, q, e);
    $display("done t_regs");
endtask
task automatic t_tick;
    int a, b, c;
    apb(1'h1, CSR, 32'h02, q, e); // whole-byte writes only
    tick(a);
    tick(a);
    apb(1'h0, CSR, 32'h0, q, e);
    chk("flag_clear", 1'h0, q[0]);
    for (int k = 1; k < 5; k++)
    begin
        apb(1'h1, CSR, 32'h02 | ((k % 4) << 2), q, e);
        tick(b);
        chk("period_old", per[(k - 1) % 4], b - a);
        tick(c);
        chk("period_new", per[k % 4], c - b);
        a = c;
    end
    mask <= 1'h1;
    repeat (20) @(posedge clk);
    chk("irq_masked", 1'h0, irq);
    apb(1'h0, CSR, 32'h0, q, e);
    chk("flag_masked", 1'h1, q[0]);
    mask <= 1'h0;
    $display("done t_tick");
endtask
task automatic t_presc;
    int n, t0;
    for (int k = 0; k < 5; k++)
    begin
        apb(1'h1, CSR, k == 0 ? 32'h80 : 32'h90 | ((k - 1) << 5), q, e);
        repeat (40) @(posedge clk);
        n = 0;
        t0 = co_cnt;
        repeat (64)
        begin
            @(posedge clk);
            n += cpu_en;
        end
        chk("cpu_rate", 64 >> k, n);
        chk("co_toggles", 64 >> k, co_cnt - t0);
        chk("co_oe", 1'h1, co_oe);
    end
    apb(1'h1, CSR, 32'h0, q, e);
    repeat (4) @(posedge clk);
    chk("co_free", 1'h0, co_oe);
    $display("done t_presc");
endtask
task automatic t_tone;
    for (int k = 1; k < 4; k++)
    begin
        apb(1'h1, TONE, k, q, e);
        repeat (3 * half[k] + 4) @(posedge clk);
        chk("tone_oe", 1'h1, tn_oe);
        chk("tone_half", half[k], tn_half);
    end
    apb(1'h1, TONE, 32'h0, q, e);
    repeat (4) @(posedge clk);
    chk("tone_off", 1'h0, tn_oe);
    $display("done t_tone");
endtask
task automatic t_halt;
    int a, n;
    apb(1'h1, TONE, 32'h1, q, e);
    apb(1'h1, CSR, 32'h8E, q, e);
    tick(a);
    tick(a);
    repeat (2) @(posedge clk);
    halt_now();
    chk("act_halt", 1'h1, ahalt);
    chk("co_halt", 1'h0, co_oe);
    chk("tone_act", 1'h1, tn_oe);
    for (n = 0; n < 260 && ahalt === 1'h1; n++)
        @(posedge clk);
    chk("tick_wake", 1'h1, n > 150 && n < 260);
    apb(1'h1, CSR, 32'h0, q, e);
    halt_now();
    chk("full_halt", 1'h1, fhalt);
    chk("tone_full", 1'h0, tn_oe);
    repeat (450) @(posedge clk);
    chk("halt_held", 1'h1, fhalt);
    wake <= 1'h1;
    @(posedge clk);
    wake <= 1'h0;
    repeat (4) @(posedge clk);
    chk("woken", 1'h0, fhalt);
    $display("done t_halt");
endtask
// ----------------------------------
// sequence, watchdog and verdict
// ----------------------------------
task automatic give_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask
initial
begin
    repeat (5) @(posedge clk);
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
    t_regs();
    t_tick();
    t_presc();
    t_tone();
    t_halt();
    give_verdict();
end
// tests need some 44000 cycles, mostly the real tone counts; a hang ends here
initial
begin
    #250000;
    miscompares++;
    give_verdict();
end
endmodule // tb_main_clock_rtc_beeper
